// ### logic/gpio_pin_configuration.sv
// pin configuration registers, pin 16 multiplexing and intrusion latch
//
// Overview of operation
// [RULE1] shared bit 0: 1 = pin 16, 0 = alarm
// [RULE2] writing 1 to bit 1 clears intrusion latch
// [RULE3] clear bit holds until software writes 0
// [RULE4] bit 2 selects 1.82 V or 2.5 V reference
// [RULE5] shared bits 5 to 3 read zero
// [RULE6] bit 6 sets pin 16 direction
// [RULE7] bit 7 sets pin 16 polarity
// [RULE8] low group at 08h, resets to 00h
// [RULE9] even bits set direction of pins 0-3
// [RULE10] odd bits set polarity of pins 0-3
// [RULE11] second group resets to 00h, inputs active low
// [RULE12] even bits set direction of pins 4-7
// [RULE13] odd bits set polarity of pins 4-7
// [RULE14] shared register at 07h, resets to 00h
// [RULE15] polarity applied both ways, driver by direction
// [RULE16] pin 16 settings apply only in pin mode
`timescale 1ns/1ps
`default_nettype none
`include "gpio_cfg_defines.svh"

module gpio_pin_configuration (
  input  wire logic                     clk_in,
  input  wire logic                     rstn_in,
  input  wire gpio_cfg_pkg::reg_req_t   reg_req_in,
  output var  gpio_cfg_pkg::reg_rsp_t   reg_rsp_out,
  input  wire logic [7:0]               user_pin_in,
  output logic      [7:0]               user_pin_out,
  output logic      [7:0]               user_pin_oe_out,
  input  wire logic [7:0]               user_value_in,
  output logic      [7:0]               user_value_out,
  input  wire logic                     user_pin_16_in,
  output logic                          user_pin_16_out,
  output logic                          user_pin_16_oe_out,
  input  wire logic                     user_value_16_in,
  output logic                          user_value_16_out,
  input  wire logic                     thermal_alarm_in,
  input  wire logic                     intrusion_event_in,
  output logic                          chassis_intrusion_latch_out,
  output logic                          vref_select_out
);

  // ==================================================
  // register file
  logic [7:0] shared_cfg;
  logic [7:0] group_low;
  logic [7:0] group_second;
  logic [7:0] next_shared_cfg;
  logic [7:0] next_group_low;
  logic [7:0] next_group_second;
  gpio_cfg_pkg::reg_rsp_t next_rsp;
  logic       clear_write;

  always_comb begin
    next_shared_cfg   = shared_cfg;
    next_group_low    = group_low;
    next_group_second = group_second;
    next_rsp.valid    = reg_req_in.rd;
    next_rsp.data     = `READ_ZERO;
    clear_write       = 1'b0;
    if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        // [RULE3] [RULE14] shared write, clear bit kept
        `ADDR_SHARED_CFG: begin
          // unused bits never stored, so they read zero
          next_shared_cfg = reg_req_in.wdata & `SHARED_WRITE_MASK;
          clear_write     = reg_req_in.wdata[`BIT_INTR_CLEAR];
        end
        // [RULE8] low group write
        `ADDR_GROUP_LOW: begin
          next_group_low = reg_req_in.wdata;
        end
        // [RULE11] second group write
        `ADDR_GROUP_SECOND: begin
          next_group_second = reg_req_in.wdata;
        end
        default: begin
          next_group_low = group_low;
        end
      endcase
    end
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        // [RULE5] unused bits masked
        `ADDR_SHARED_CFG:   next_rsp.data = shared_cfg & `SHARED_WRITE_MASK;
        `ADDR_GROUP_LOW:    next_rsp.data = group_low;
        `ADDR_GROUP_SECOND: next_rsp.data = group_second;
        default:            next_rsp.data = `READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shared_cfg   <= `RESET_SHARED_CFG;
      group_low    <= `RESET_GROUP_LOW;
      group_second <= `RESET_GROUP_SECOND;
      reg_rsp_out  <= '0;
    end else begin
      shared_cfg   <= next_shared_cfg;
      group_low    <= next_group_low;
      group_second <= next_group_second;
      reg_rsp_out  <= next_rsp;
    end
  end

  // ==================================================
  // intrusion latch and reference select
  logic next_latch;
  logic next_vref;

  always_comb begin
    // [RULE2] clear on write of 1, a same-cycle event still wins
    next_latch = intrusion_event_in |
                 (chassis_intrusion_latch_out & ~clear_write);
    // [RULE4] reference level select
    next_vref  = shared_cfg[`BIT_VREF_SEL];
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chassis_intrusion_latch_out <= 1'b0;
      vref_select_out             <= 1'b0;
    end else begin
      chassis_intrusion_latch_out <= next_latch;
      vref_select_out             <= next_vref;
    end
  end

  // ==================================================
  // pins 0 to 7
  logic [15:0] pin_cfg;
  logic [7:0]  pin_dir;
  logic [7:0]  pin_pol;
  logic [7:0]  next_pin_out;
  logic [7:0]  next_pin_oe;
  logic [7:0]  next_value;

  assign pin_cfg = {group_second, group_low};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      // [RULE9] [RULE12] direction on even bits
      assign pin_dir[gi]      = pin_cfg[2*gi];
      // [RULE10] [RULE13] polarity on odd bits
      assign pin_pol[gi]      = pin_cfg[2*gi+1];
      // [RULE15] active low inverts both ways
      assign next_pin_out[gi] = user_value_in[gi] ^ ~pin_pol[gi];
      assign next_pin_oe[gi]  = pin_dir[gi];
      assign next_value[gi]   = user_pin_in[gi] ^ ~pin_pol[gi];
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      user_pin_out    <= '0;
      user_pin_oe_out <= '0;
      user_value_out  <= '0;
    end else begin
      user_pin_out    <= next_pin_out;
      user_pin_oe_out <= next_pin_oe;
      user_value_out  <= next_value;
    end
  end

  // ==================================================
  // multiplexed pin 16
  logic sel16;
  logic dir16;
  logic pol16;
  logic next_p16_out;
  logic next_p16_oe;
  logic next_value16;

  always_comb begin
    sel16        = shared_cfg[`BIT_PIN16_SEL];
    dir16        = shared_cfg[`BIT_PIN16_DIR];
    pol16        = shared_cfg[`BIT_PIN16_POL];
    // alarm mode: pin driven low while the alarm is active
    next_p16_out = ~thermal_alarm_in;
    next_p16_oe  = 1'b1;
    next_value16 = 1'b0;
    // [RULE1] [RULE16] general-purpose mode
    if (sel16) begin
      // [RULE6] [RULE7] direction and polarity
      next_p16_out = user_value_16_in ^ ~pol16;
      next_p16_oe  = dir16;
      next_value16 = user_pin_16_in ^ ~pol16;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      user_pin_16_out    <= 1'b0;
      user_pin_16_oe_out <= 1'b0;
      user_value_16_out  <= 1'b0;
    end else begin
      user_pin_16_out    <= next_p16_out;
      user_pin_16_oe_out <= next_p16_oe;
      user_value_16_out  <= next_value16;
    end
  end

  // ==================================================
  // assertions
  sequence s_write_shared;
    reg_req_in.wr && reg_req_in.addr == `ADDR_SHARED_CFG;
  endsequence

  sequence s_clear_no_event;
    s_write_shared ##0 reg_req_in.wdata[`BIT_INTR_CLEAR] && !intrusion_event_in;
  endsequence

  property p_alarm_mode;
    @(posedge clk_in) disable iff (!rstn_in)
    !sel16 |=> user_pin_16_oe_out && user_pin_16_out == !$past(thermal_alarm_in);
  endproperty
  a_alarm_mode: assert property (p_alarm_mode) // [RULE1]
    else $error("pin 16 not carrying the alarm");

  property p_intrusion_clear;
    @(posedge clk_in) disable iff (!rstn_in)
    s_clear_no_event |=> !chassis_intrusion_latch_out;
  endproperty
  a_intrusion_clear: assert property (p_intrusion_clear) // [RULE2]
    else $error("intrusion latch not cleared");

  property p_event_wins;
    @(posedge clk_in) disable iff (!rstn_in)
    intrusion_event_in |=> chassis_intrusion_latch_out;
  endproperty
  a_event_wins: assert property (p_event_wins) // [RULE2]
    else $error("intrusion event lost");

  property p_clear_holds;
    @(posedge clk_in) disable iff (!rstn_in)
    shared_cfg[`BIT_INTR_CLEAR] && !reg_req_in.wr |=> shared_cfg[`BIT_INTR_CLEAR];
  endproperty
  a_clear_holds: assert property (p_clear_holds) // [RULE3]
    else $error("clear bit changed without a write");

  property p_vref;
    @(posedge clk_in) disable iff (!rstn_in)
    s_write_shared |=> ##1 vref_select_out == $past(reg_req_in.wdata[`BIT_VREF_SEL], 2);
  endproperty
  a_vref: assert property (p_vref) // [RULE4]
    else $error("reference select does not follow bit 2");

  property p_unused_zero;
    @(posedge clk_in) disable iff (!rstn_in)
    reg_req_in.rd && reg_req_in.addr == `ADDR_SHARED_CFG |=>
      reg_rsp_out.valid && reg_rsp_out.data[5:3] == 3'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) // [RULE5]
    else $error("unused bits read nonzero");

  property p_pin16_dir;
    @(posedge clk_in) disable iff (!rstn_in)
    sel16 |=> user_pin_16_oe_out == $past(dir16);
  endproperty
  a_pin16_dir: assert property (p_pin16_dir) // [RULE6]
    else $error("pin 16 driver not following direction");

  property p_pin16_pol;
    @(posedge clk_in) disable iff (!rstn_in)
    sel16 |=> user_pin_16_out == ($past(user_value_16_in) ^ !$past(pol16)) &&
              user_value_16_out == ($past(user_pin_16_in) ^ !$past(pol16));
  endproperty
  a_pin16_pol: assert property (p_pin16_pol) // [RULE7]
    else $error("pin 16 polarity wrong");

  property p_reset_values;
    @(posedge clk_in)
    !rstn_in |=> shared_cfg == 8'h00 && group_low == 8'h00 && group_second == 8'h00;
  endproperty
  a_reset_values: assert property (p_reset_values) // [RULE8] [RULE11] [RULE14]
    else $error("register not zero in reset");

  property p_low_write;
    @(posedge clk_in) disable iff (!rstn_in)
    reg_req_in.wr && reg_req_in.addr == `ADDR_GROUP_LOW
      |=> group_low == $past(reg_req_in.wdata) ##1
          user_pin_oe_out[3:0] == $past({group_low[6], group_low[4], group_low[2], group_low[0]});
  endproperty
  a_low_write: assert property (p_low_write) // [RULE9]
    else $error("low group direction wrong");

  property p_low_pol;
    @(posedge clk_in) disable iff (!rstn_in)
    1'b1 |=> user_pin_out[0] == ($past(user_value_in[0]) ^ !$past(group_low[1])) &&
             user_pin_out[3] == ($past(user_value_in[3]) ^ !$past(group_low[7]));
  endproperty
  a_low_pol: assert property (p_low_pol) // [RULE10]
    else $error("low group polarity wrong");

  property p_second_dir;
    @(posedge clk_in) disable iff (!rstn_in)
    1'b1 |=> user_pin_oe_out[7:4] == $past({group_second[6], group_second[4],
                                            group_second[2], group_second[0]});
  endproperty
  a_second_dir: assert property (p_second_dir) // [RULE12]
    else $error("second group direction wrong");

  property p_second_pol;
    @(posedge clk_in) disable iff (!rstn_in)
    1'b1 |=> user_value_out[4] == ($past(user_pin_in[4]) ^ !$past(group_second[1])) &&
             user_value_out[7] == ($past(user_pin_in[7]) ^ !$past(group_second[7]));
  endproperty
  a_second_pol: assert property (p_second_pol) // [RULE13]
    else $error("second group polarity wrong");

  property p_shared_write;
    @(posedge clk_in) disable iff (!rstn_in)
    s_write_shared |=> shared_cfg == ($past(reg_req_in.wdata) & 8'hc7);
  endproperty
  a_shared_write: assert property (p_shared_write) // [RULE14]
    else $error("shared register write not taken");

  property p_input_dir;
    @(posedge clk_in) disable iff (!rstn_in)
    !pin_dir[5] |=> !user_pin_oe_out[5];
  endproperty
  a_input_dir: assert property (p_input_dir) // [RULE15]
    else $error("driver enabled on an input");

  property p_pin16_gated;
    @(posedge clk_in) disable iff (!rstn_in)
    !sel16 |=> !user_value_16_out;
  endproperty
  a_pin16_gated: assert property (p_pin16_gated) // [RULE16]
    else $error("pin 16 settings active in alarm mode");

endmodule
`default_nettype wire

// ### logic/gpio_cfg_defines.svh
// offsets, field positions, reset values and masks of the pin configuration block
`ifndef GPIO_CFG_DEFINES_SVH
`define GPIO_CFG_DEFINES_SVH

// ==================================================
// register offsets
`define ADDR_SHARED_CFG     8'h07
`define ADDR_GROUP_LOW      8'h08
`define ADDR_GROUP_SECOND   8'h09

// ==================================================
// reset values
`define RESET_SHARED_CFG    8'h00
`define RESET_GROUP_LOW     8'h00
`define RESET_GROUP_SECOND  8'h00

// ==================================================
// shared register fields
`define BIT_PIN16_SEL       0
`define BIT_INTR_CLEAR      1
`define BIT_VREF_SEL        2
`define BIT_PIN16_DIR       6
`define BIT_PIN16_POL       7
`define SHARED_WRITE_MASK   8'hc7
`define READ_ZERO           8'h00

`endif

// ### logic/gpio_cfg_pkg.sv
// types shared by the pin configuration block
`default_nettype none
package gpio_cfg_pkg;

  // one register access from the management interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // register answer
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } reg_rsp_t;

endpackage
`default_nettype wire

// ### dv/gpio_pin_configuration_tb.sv
// self-checking bench for the pin configuration block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_cfg_defines.svh"

module gpio_pin_configuration_tb;
  // ==================================================
  // clock, stimulus and design
  logic                   clk_in  = 1'b0;
  logic                   rstn_in = 1'b0;
  gpio_cfg_pkg::reg_req_t req     = '0;
  gpio_cfg_pkg::reg_rsp_t rsp;
  logic [7:0]             pin     = 8'h00;
  logic [7:0]             val     = 8'h00;
  logic [7:0]             pout;
  logic [7:0]             poe;
  logic [7:0]             vout;
  logic                   p16     = 1'b0;
  logic                   v16     = 1'b0;
  logic                   alarm   = 1'b0;
  logic                   ev      = 1'b0;
  logic                   p16o;
  logic                   p16oe;
  logic                   v16o;
  logic                   latch_o;
  logic                   vref_o;
  // behavioural model
  logic [7:0]             sh;
  logic [7:0]             lo;
  logic [7:0]             se;
  logic                   latch;
  logic [31:0]            lf;
  logic [7:0]             a;
  logic [7:0]             c_addr [4] = '{8'h07, 8'h08, 8'h09, 8'h0a};
  int                     bad_count = 0;
  int                     compares  = 0;

  always #20 clk_in = ~clk_in;

  gpio_pin_configuration DUT (
    .clk_in                      (clk_in),
    .rstn_in                     (rstn_in),
    .reg_req_in                  (req),
    .reg_rsp_out                 (rsp),
    .user_pin_in                 (pin),
    .user_pin_out                (pout),
    .user_pin_oe_out             (poe),
    .user_value_in               (val),
    .user_value_out              (vout),
    .user_pin_16_in              (p16),
    .user_pin_16_out             (p16o),
    .user_pin_16_oe_out          (p16oe),
    .user_value_16_in            (v16),
    .user_value_16_out           (v16o),
    .thermal_alarm_in            (alarm),
    .intrusion_event_in          (ev),
    .chassis_intrusion_latch_out (latch_o),
    .vref_select_out             (vref_o)
  );

  // ==================================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] mread(input logic [7:0] ad);
    case (ad)
      8'h07:   return sh;
      8'h08:   return lo;
      8'h09:   return se;
      default: return 8'h00;
    endcase
  endfunction

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic mreset();
    sh    = 8'h00;
    lo    = 8'h00;
    se    = 8'h00;
    latch = 1'b0;
  endtask

  // entered at a falling edge; request stands for exactly one rising edge
  task automatic bus(input logic w, input logic r, input logic [7:0] ad, input logic [7:0] d);
    logic [7:0] e;
    e   = mread(ad);
    req = '{wr: w, rd: r, addr: ad, wdata: d};
    @(negedge clk_in);
    if (w && ad == 8'h07) begin
      // bits 5 to 3 never stored
      sh = d & 8'hc7;
      if (d[1]) begin
        latch = 1'b0;
      end
    end
    if (w && ad == 8'h08) begin
      lo = d;
    end
    if (w && ad == 8'h09) begin
      se = d;
    end
    if (r) begin
      cmp("rsp_valid", 8'h01, {7'h00, rsp.valid});
      cmp("rsp_data", e, rsp.data);
    end
  endtask

  task automatic idle();
    req = '0;
    @(negedge clk_in);
    cmp("rsp_idle", 8'h00, {7'h00, rsp.valid});
  endtask

  task automatic settle();
    idle();
    repeat (2) @(negedge clk_in);
  endtask

  task automatic chk_out();
    logic [15:0] c;
    logic [7:0]  ed;
    logic [7:0]  eo;
    logic [7:0]  evl;
    logic [7:0]  e16;
    c = {se, lo};
    for (int i = 0; i < 8; i++) begin
      ed[i]  = c[2*i];
      eo[i]  = val[i] ^ ~c[2*i+1];
      evl[i] = pin[i] ^ ~c[2*i+1];
    end
    // alarm mode drives inverted alarm regardless of pin 16 settings
    if (sh[0]) begin
      e16 = {5'h00, sh[6], (v16 ^ ~sh[7]) & sh[6], p16 ^ ~sh[7]};
    end else begin
      e16 = {5'h00, 1'b1, ~alarm, 1'b0};
    end
    cmp("pin_oe", ed, poe);
    cmp("pin_out", eo & ed, pout & ed);
    cmp("pin_value", evl, vout);
    cmp("pin16", e16, {5'h00, p16oe, p16o & e16[2], v16o});
    cmp("vref_latch", {6'h00, sh[2], latch}, {6'h00, vref_o, latch_o});
  endtask

  task automatic test_done();
    $display("TB: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==================================================
  // watchdog, about sixteen times the expected run
  initial begin
    #200000;
    bad_count++;
    test_done();
  end

  // ==================================================
  // tests
  initial begin
    lf = 32'h0000_2b05;
    mreset();
    repeat (16) @(negedge clk_in);
    cmp("reset_oe", 8'h00, poe | {7'h00, p16oe});
    rstn_in = 1'b1;
    settle();
    chk_out();
    bus(1'b0, 1'b1, 8'h07, 8'h00);
    bus(1'b0, 1'b1, 8'h08, 8'h00);
    bus(1'b0, 1'b1, 8'h09, 8'h00);
    idle();
    $display("TB: test reset done");
    // all ones into each place, unmapped one included
    foreach (c_addr[k]) begin
      bus(1'b1, 1'b0, c_addr[k], 8'hff);
      bus(1'b0, 1'b1, c_addr[k], 8'h00);
      idle();
    end
    $display("TB: test register map done");
    for (int n = 0; n < 40; n++) begin
      lf = lfsr_next(lf);
      case (lf[9:8])
        2'd0:    a = 8'h07;
        2'd1:    a = 8'h08;
        2'd2:    a = 8'h09;
        default: a = lf[7:0] | 8'h10;
      endcase
      // write and read together return the old value
      bus(1'b1, lf[10], a, lf[23:16]);
      bus(1'b0, 1'b1, a, 8'h00);
      idle();
      lf = lfsr_next(lf);
      {pin, val, p16, v16, alarm} = lf[18:0];
      settle();
      chk_out();
    end
    $display("TB: test random done");
    // intrusion latch set, cleared, held clear bit, event beats clear
    ev = 1'b1;
    @(negedge clk_in);
    ev    = 1'b0;
    latch = 1'b1;
    settle();
    chk_out();
    bus(1'b1, 1'b0, 8'h07, sh | 8'h02);
    settle();
    chk_out();
    bus(1'b0, 1'b1, 8'h07, 8'h00);
    ev = 1'b1;
    @(negedge clk_in);
    ev    = 1'b0;
    latch = 1'b1;
    settle();
    chk_out();
    ev = 1'b1;
    bus(1'b1, 1'b0, 8'h07, sh | 8'h02);
    ev    = 1'b0;
    latch = 1'b1;
    settle();
    chk_out();
    bus(1'b1, 1'b0, 8'h07, sh & 8'hfd);
    bus(1'b0, 1'b1, 8'h07, 8'h00);
    settle();
    chk_out();
    $display("TB: test intrusion done");
    rstn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rstn_in = 1'b1;
    mreset();
    bus(1'b0, 1'b1, 8'h07, 8'h00);
    bus(1'b0, 1'b1, 8'h08, 8'h00);
    bus(1'b0, 1'b1, 8'h09, 8'h00);
    settle();
    chk_out();
    $display("TB: test second reset done");
    test_done();
  end

endmodule
`default_nettype wire
